// ---- include/dcsa_pkg.sv ----
package dcsa_pkg;

  localparam int unsigned CNT_W  = 24;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SRC    = 8'h04;
  localparam logic [7:0] REG_DST    = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0c;
  localparam logic [7:0] REG_POFF   = 8'h10;
  localparam logic [7:0] REG_SOFF   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // channel_control field positions
  localparam int unsigned CTL_EN_BIT = 23;
  localparam int unsigned CTL_TM_LSB = 19;
  localparam int unsigned CTL_CM_LSB = 0;
  localparam int unsigned CTL_SU_LSB = 3;
  localparam int unsigned CTL_DU_LSB = 5;

  // status field positions
  localparam int unsigned STS_DONE_BIT  = 0;
  localparam int unsigned STS_BUSY_BIT  = 1;
  localparam int unsigned STS_ARMED_BIT = 2;

  // transfer_mode_select codes
  localparam logic [2:0] TM_REQ_BLOCK      = 3'h0;
  localparam logic [2:0] TM_REQ_WORD       = 3'h1;
  localparam logic [2:0] TM_REQ_LINE       = 3'h2;
  localparam logic [2:0] TM_EN_BLOCK       = 3'h3;
  localparam logic [2:0] TM_REQ_BLOCK_KEEP = 3'h4;
  localparam logic [2:0] TM_REQ_WORD_KEEP  = 3'h5;

  // counter modes: single, dual, three triple layouts
  localparam logic [2:0] CM_A = 3'h0;
  localparam logic [2:0] CM_B = 3'h1;
  localparam logic [2:0] CM_C = 3'h2;
  localparam logic [2:0] CM_D = 3'h3;
  localparam logic [2:0] CM_E = 3'h4;

  // section widths (low, middle); high takes the rest
  localparam logic [4:0] LOW_W_B = 5'h0c;
  localparam logic [4:0] LOW_W_C = 5'h08;
  localparam logic [4:0] MID_W_C = 5'h08;
  localparam logic [4:0] LOW_W_D = 5'h06;
  localparam logic [4:0] MID_W_D = 5'h06;
  localparam logic [4:0] LOW_W_E = 5'h0c;
  localparam logic [4:0] MID_W_E = 5'h06;

  // address update selection per pointer
  localparam logic [1:0] UPD_HOLD    = 2'h0;
  localparam logic [1:0] UPD_LINEAR  = 2'h1;
  localparam logic [1:0] UPD_COUNTER = 2'h2;

  // step class chosen by the counter test
  localparam logic [1:0] STEP_ONE = 2'h0;
  localparam logic [1:0] STEP_PRI = 2'h1;
  localparam logic [1:0] STEP_SEC = 2'h2;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [23:0] REG_RST     = 24'h00_0000;
  localparam logic [23:0] ONE24       = 24'h00_0001;

  typedef struct packed {
    logic [23:0] lmask;
    logic [23:0] mmask;
    logic [23:0] mone;
    logic [23:0] hone;
    logic        triple;
  } dcsa_layout_t;

  function automatic dcsa_layout_t dcsa_layout(input logic [2:0] m);
    dcsa_layout_t l;
    logic [4:0]   lw;
    logic [4:0]   mw;
    lw = 5'h18;
    mw = 5'h00;
    case (m)
      CM_B: lw = LOW_W_B;
      CM_C: begin
        lw = LOW_W_C;
        mw = MID_W_C;
      end
      CM_D: begin
        lw = LOW_W_D;
        mw = MID_W_D;
      end
      CM_E: begin
        lw = LOW_W_E;
        mw = MID_W_E;
      end
      default: lw = 5'h18;
    endcase
    // a shift by the full width wraps to all ones after the subtract
    l.lmask  = (ONE24 << lw) - ONE24;
    l.mmask  = ((ONE24 << (lw + mw)) - ONE24) & ~l.lmask;
    l.mone   = ONE24 << lw;
    l.hone   = ONE24 << (lw + mw);
    l.triple = (mw != 5'h00);
    return l;
  endfunction : dcsa_layout

  function automatic logic [31:0] dcsa_strb(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : dcsa_strb

endpackage : dcsa_pkg

// ---- rtl/dcsa_sync2.sv ----
`timescale 1ns/1ps
module dcsa_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level in, level out
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } dcsa_sync_t;

  dcsa_sync_t q;
  dcsa_sync_t d;

  always_comb begin
    d.meta = async_in;
    d.sync = q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.sync;

endmodule : dcsa_sync2

// ---- rtl/dcsa_step.sv ----
`timescale 1ns/1ps
module dcsa_step (
  // counter state
  input  wire logic [2:0]  cmode,
  input  wire logic [23:0] count,
  input  wire logic [23:0] pre,
  // decision
  output logic      [23:0] nxt_count,
  output logic      [1:0]  step_sel,
  output logic             last,
  output logic             low_wrap
);
  import dcsa_pkg::*;

  dcsa_layout_t lay;
  logic [23:0]  lo;
  logic [23:0]  mi;
  logic [23:0]  hi;

  always_comb begin
    lay      = dcsa_layout(cmode);
    lo       = count & lay.lmask;
    mi       = count & lay.mmask;
    hi       = count & ~(lay.lmask | lay.mmask);
    low_wrap = (lo == REG_RST);
    last     = 1'b0;
    if (lo != REG_RST) begin
      // inner step: low section down, pointer forward by one
      nxt_count = count - ONE24;
      step_sel  = STEP_ONE;
    end else if (mi != REG_RST) begin
      nxt_count = (count - lay.mone) | (pre & lay.lmask);
      step_sel  = STEP_PRI;
    end else if (hi != REG_RST) begin
      nxt_count = (count - lay.hone) | (pre & (lay.lmask | lay.mmask));
      step_sel  = lay.triple ? STEP_SEC : STEP_PRI;
    end else begin
      // whole counter at zero: last word, full reload
      nxt_count = pre;
      last      = 1'b1;
      if (cmode == CM_A) begin
        step_sel = STEP_ONE;
      end else begin
        step_sel = lay.triple ? STEP_SEC : STEP_PRI;
      end
    end
  end

endmodule : dcsa_step

// ---- rtl/dcsa_channel.sv ----
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dcsa_channel (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // axi4-lite write
  input  wire logic [dcsa_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [dcsa_pkg::AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [dcsa_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [dcsa_pkg::AXI_DW-1:0]   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // memory side
  input  wire logic                          dma_request,
  output logic                               xfer_req,
  output logic      [dcsa_pkg::CNT_W-1:0]    xfer_src_addr,
  output logic      [dcsa_pkg::CNT_W-1:0]    xfer_dst_addr,
  input  wire logic                          xfer_ack,
  output logic                               block_end
);
  import dcsa_pkg::*;

  typedef enum logic {FSM_IDLE, FSM_XFER} dcsa_fsm_t;

  typedef struct packed {
    dcsa_fsm_t   fsm;
    logic        enable;
    logic [2:0]  tmode;
    logic [2:0]  cmode;
    logic [1:0]  src_upd;
    logic [1:0]  dst_upd;
    logic [23:0] src;
    logic [23:0] dst;
    logic [23:0] count;
    logic [23:0] pre;
    logic [23:0] poff;
    logic [23:0] soff;
    logic        blk_done;
    logic        armed;
    logic        xfer_valid;
    logic        blk_pulse;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dcsa_state_t;

  dcsa_state_t q;
  dcsa_state_t d;
  logic        req_s;
  logic [23:0] stp_count;
  logic [1:0]  stp_sel;
  logic        stp_last;
  logic        stp_wrap;
  logic        ack_fire;
  logic        wr_fire;
  logic [32:0] wr_old;
  logic [31:0] wr_val;
  logic [32:0] rd_val;

  dcsa_sync2 u_req_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (dma_request),
    .sync_out (req_s)
  );

  dcsa_step u_step (
    .cmode     (q.cmode),
    .count     (q.count),
    .pre       (q.pre),
    .nxt_count (stp_count),
    .step_sel  (stp_sel),
    .last      (stp_last),
    .low_wrap  (stp_wrap)
  );

  // {hit, data} for a register offset
  function automatic logic [32:0] reg_read(input dcsa_state_t s, input logic [7:0] a);
    logic [31:0] v;
    logic        hit;
    v   = 32'h0000_0000;
    hit = 1'b1;
    case (a)
      REG_CTRL: begin
        v[CTL_EN_BIT]            = s.enable;
        v[CTL_TM_LSB +: 3]       = s.tmode;
        v[CTL_CM_LSB +: 3]       = s.cmode;
        v[CTL_SU_LSB +: 2]       = s.src_upd;
        v[CTL_DU_LSB +: 2]       = s.dst_upd;
      end
      REG_SRC:   v[23:0] = s.src;
      REG_DST:   v[23:0] = s.dst;
      REG_COUNT: v[23:0] = s.count;
      REG_POFF:  v[23:0] = s.poff;
      REG_SOFF:  v[23:0] = s.soff;
      REG_STATUS: begin
        v[STS_DONE_BIT]  = s.blk_done;
        v[STS_BUSY_BIT]  = (s.fsm == FSM_XFER);
        v[STS_ARMED_BIT] = s.armed;
      end
      default: hit = 1'b0;
    endcase
    return {hit, v};
  endfunction : reg_read

  // pointer update, each pointer picks its own style
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] upd,
                                            input logic [1:0] sel, input logic [23:0] po,
                                            input logic [23:0] so);
    logic [23:0] r;
    r = a;
    if (upd == UPD_LINEAR) begin
      r = a + ONE24;
    end else if (upd == UPD_COUNTER) begin
      case (sel)
        STEP_PRI: r = a + po;
        STEP_SEC: r = a + so;
        default:  r = a + ONE24;
      endcase
    end
    return r;
  endfunction : next_addr

  assign ack_fire = (q.fsm == FSM_XFER) && xfer_ack;
  assign wr_fire  = q.aw_got && q.w_got && !q.bvalid;
  assign wr_old   = reg_read(q, q.waddr);
  assign wr_val   = dcsa_strb(wr_old[31:0], q.wdata, q.wstrb);
  assign rd_val   = reg_read(q, s_axi_araddr);

  always_comb begin
    d           = q;
    d.blk_pulse = 1'b0;

    // transfer engine
    case (q.fsm)
      FSM_IDLE: begin
        // software clearing enable stops only between words
        if (q.enable && (q.armed || q.tmode == TM_EN_BLOCK || req_s)) begin
          d.fsm        = FSM_XFER;
          d.xfer_valid = 1'b1;
        end
      end
      FSM_XFER: begin
        if (xfer_ack) begin
          d.fsm        = FSM_IDLE;
          d.xfer_valid = 1'b0;
          d.count      = stp_count;
          d.src = next_addr(q.src, q.src_upd, stp_sel, q.poff, q.soff);
          d.dst = next_addr(q.dst, q.dst_upd, stp_sel, q.poff, q.soff);
          case (q.tmode)
            TM_REQ_WORD, TM_REQ_WORD_KEEP: d.armed = 1'b0;
            TM_REQ_LINE:                   d.armed = !stp_wrap;
            default:                       d.armed = !stp_last;
          endcase
          if (stp_last) begin
            d.blk_done  = 1'b1;
            d.blk_pulse = 1'b1;
            if (q.tmode != TM_REQ_BLOCK_KEEP && q.tmode != TM_REQ_WORD_KEEP) begin
              d.enable = 1'b0;
            end
            // modes 100 and 101 leave enable set for the next request
          end
        end
      end
      default: begin
        d.fsm        = FSM_IDLE;
        d.xfer_valid = 1'b0;
      end
    endcase

    // write address and data taken in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_got  = 1'b1;
      d.waddr   = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_got  = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
      d.wready = 1'b0;
    end

    // register write; software data wins over the engine update, except a done clear in a block-end cycle
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
      case (q.waddr)
        REG_CTRL: begin
          d.enable  = wr_val[CTL_EN_BIT];
          d.tmode   = wr_val[CTL_TM_LSB +: 3];
          d.cmode   = wr_val[CTL_CM_LSB +: 3];
          d.src_upd = wr_val[CTL_SU_LSB +: 2];
          d.dst_upd = wr_val[CTL_DU_LSB +: 2];
          d.armed   = 1'b0;
        end
        REG_SRC:  d.src = wr_val[23:0];
        REG_DST:  d.dst = wr_val[23:0];
        REG_COUNT: begin
          d.count = wr_val[23:0];
          d.pre   = wr_val[23:0];
        end
        REG_POFF: d.poff = wr_val[23:0];
        REG_SOFF: d.soff = wr_val[23:0];
        REG_STATUS: begin
          // write one to clear; a block end in the same cycle still sets
          if (q.wstrb[0] && q.wdata[STS_DONE_BIT] && !(ack_fire && stp_last)) begin
            d.blk_done = 1'b0;
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // register read
    if (q.arready && s_axi_arvalid) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = rd_val[31:0];
      d.rresp   = rd_val[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.fsm     <= FSM_IDLE;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign xfer_req      = q.xfer_valid;
  assign xfer_src_addr = q.src;
  assign xfer_dst_addr = q.dst;
  assign block_end     = q.blk_pulse;

  property p_en_trigger;
    @(posedge clk) disable iff (!rst_n)
      q.fsm == FSM_IDLE && q.enable && q.tmode == TM_EN_BLOCK |=> xfer_req;
  endproperty
  a_en_trigger: assert property (p_en_trigger) else $error("enable trigger gave no transfer");

  property p_hold_addr;
    @(posedge clk) disable iff (!rst_n)
      xfer_req && !xfer_ack && !wr_fire |=> xfer_req && $stable(xfer_src_addr);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("transfer address moved early");

  property p_single_dec;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_A && q.count != REG_RST
      |=> q.count == $past(q.count) - ONE24 && !block_end;
  endproperty
  a_single_dec: assert property (p_single_dec) else $error("single count did not step");

  property p_single_reload;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_A && q.count == REG_RST
      |=> q.count == $past(q.pre) && block_end && q.blk_done;
  endproperty
  a_single_reload: assert property (p_single_reload) else $error("single reload missed");

  property p_dst_follow;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_B && q.dst_upd == UPD_COUNTER
      && q.count[11:0] != 12'h000
      |=> xfer_dst_addr == $past(q.dst) + ONE24;
  endproperty
  a_dst_follow: assert property (p_dst_follow) else $error("destination did not step");

  property p_dual_off;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_B && q.src_upd == UPD_COUNTER
      && q.count[11:0] == 12'h000 && q.count[23:12] != 12'h000
      |=> xfer_src_addr == $past(q.src) + $past(q.poff)
          && q.count[23:12] == $past(q.count[23:12]) - 12'h001
          && q.count[11:0] == $past(q.pre[11:0]);
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("dual row step wrong");

  property p_tri_mid;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_E && q.src_upd == UPD_COUNTER
      && q.count[11:0] == 12'h000 && q.count[17:12] != 6'h00
      |=> xfer_src_addr == $past(q.src) + $past(q.poff)
          && q.count[17:12] == $past(q.count[17:12]) - 6'h01;
  endproperty
  a_tri_mid: assert property (p_tri_mid) else $error("triple middle step wrong");

  property p_tri_last;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && q.cmode == CM_E && q.src_upd == UPD_COUNTER
      && q.count == REG_RST
      |=> xfer_src_addr == $past(q.src) + $past(q.soff) && q.count == $past(q.pre);
  endproperty
  a_tri_last: assert property (p_tri_last) else $error("triple block end wrong");

  property p_keep_en;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && stp_last && q.tmode == TM_REQ_BLOCK_KEEP |=> q.enable;
  endproperty
  a_keep_en: assert property (p_keep_en) else $error("enable dropped in keep mode");

  property p_clear_en;
    @(posedge clk) disable iff (!rst_n)
      ack_fire && !wr_fire && stp_last && (q.tmode == TM_REQ_BLOCK || q.tmode == TM_EN_BLOCK)
      |=> !q.enable ##1 !xfer_req;
  endproperty
  a_clear_en: assert property (p_clear_en) else $error("enable kept after block");

  property p_preload;
    @(posedge clk) disable iff (!rst_n)
      wr_fire && q.waddr == REG_COUNT && q.wstrb == 4'hf
      |=> q.count == $past(q.wdata[23:0]) && q.pre == $past(q.wdata[23:0]);
  endproperty
  a_preload: assert property (p_preload) else $error("preload copy not captured");

  c_dual_end: cover property (@(posedge clk) disable iff (!rst_n)
    ack_fire && q.cmode == CM_B && stp_last);
  c_tri_sec: cover property (@(posedge clk) disable iff (!rst_n)
    ack_fire && q.cmode == CM_E && stp_sel == STEP_SEC && !stp_last);
  c_word_req: cover property (@(posedge clk) disable iff (!rst_n)
    ack_fire && q.tmode == TM_REQ_WORD ##[1:20] xfer_req);

endmodule : dcsa_channel

// ---- bench/dcsa_mem_model.sv ----
`timescale 1ns/1ps
module dcsa_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // word handshake
  input  wire logic       xfer_req,
  input  wire logic [3:0] wait_cycles,
  output logic            xfer_ack
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       ack;
  } dcsa_mem_st_t;
  dcsa_mem_st_t st_q;
  dcsa_mem_st_t st_d;
  // one-cycle ack: a held request must never count as two words
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    if (st_q.ack || !xfer_req) begin
      st_d.cnt = 4'h0;
    end else if (st_q.cnt == wait_cycles) begin
      st_d.ack = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign xfer_ack = st_q.ack;
endmodule : dcsa_mem_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`define CK(n, e, g) chk(n, 32'(e), 32'(g))
module tb;
  import dcsa_pkg::*;
  localparam logic [31:0] ALL_M = 32'hffff_ffff;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        dma_request = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, xfer_req, xfer_ack, block_end;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] src, dst;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;

  always #4 clk = ~clk;

  dcsa_channel dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dma_request(dma_request), .xfer_req(xfer_req), .xfer_src_addr(src),
    .xfer_dst_addr(dst), .xfer_ack(xfer_ack), .block_end(block_end));
  dcsa_mem_model mem_u (.clk(clk), .rst_n(rst_n), .xfer_req(xfer_req),
    .wait_cycles(dly), .xfer_ack(xfer_ack));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    `CK("bresp", RESP_OKAY, r);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, m);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    `CK(n, e & m, d & m);
  endtask : rd

  // both pointers follow the counter from distinct bases
  task automatic run_blk(input logic [2:0] cm, input logic [23:0] cnt, po, so,
                         input int lw, mw, n, input logic [3:0] d);
    int          l, m, h, pl, pm;
    logic [23:0] c, ea, ed, step;
    logic [31:0] ctl;
    c = cnt;
    ea = 24'h00_0100;
    ed = 24'h00_0800;
    pl = cnt & ((1 << lw) - 1);
    pm = (cnt >> lw) & ((1 << mw) - 1);
    ctl = {8'h00, 1'b1, 1'b0, TM_EN_BLOCK, 12'h000, 2'h2, 2'h2, cm};
    dly <= d;
    wr(REG_SRC, 32'(ea));
    wr(REG_DST, 32'(ed));
    wr(REG_COUNT, 32'(cnt));
    wr(REG_POFF, 32'(po));
    wr(REG_SOFF, 32'(so));
    wr(REG_CTRL, ctl);
    for (int i = 0; i < n; i++) begin
      while (xfer_req !== 1'b1) begin
        @(posedge clk);
        #1;
      end
      `CK("src", ea, src);
      `CK("dst", ed, dst);
      do @(posedge clk); while (xfer_ack !== 1'b1);
      #1;
      l = c & ((1 << lw) - 1);
      m = (c >> lw) & ((1 << mw) - 1);
      h = c >> (lw + mw);
      step = (lw == 24) ? 24'h00_0001 : ((mw != 0) ? so : po);
      if (l != 0) begin
        l--;
        step = 24'h00_0001;
      end else if (mw != 0 && m != 0) begin
        m--;
        l = pl;
        step = po;
      end else if (h != 0) begin
        h--;
        l = pl;
        m = pm;
      end else begin
        h = cnt >> (lw + mw);
        l = pl;
        m = pm;
      end
      c = 24'((h << (lw + mw)) | (m << lw) | l);
      ea += step;
      ed += step;
      `CK("block_end", i == n - 1, block_end);
    end
    `CK("src_final", ea, src);
    rd("count_reload", REG_COUNT, 32'(cnt), ALL_M);
    rd("enable_cleared", REG_CTRL, ctl & ~32'h0080_0000, ALL_M);
    rd("done_set", REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(REG_STATUS, 32'h0000_0001);
    rd("done_cleared", REG_STATUS, 32'h0000_0000, 32'h0000_0001);
    $display("block test counter mode %0d finished", cm);
  endtask : run_blk

  // one request pulse per block; software rewinds the pointer between blocks
  task automatic keep_enable();
    logic [31:0] ctl;
    ctl = {8'h00, 1'b1, 1'b0, TM_REQ_BLOCK_KEEP, 12'h000, 2'h0, 2'h1, CM_A};
    wr(REG_SRC, 32'h0000_0040);
    wr(REG_COUNT, 32'h0000_0001);
    wr(REG_CTRL, ctl);
    for (int b = 0; b < 2; b++) begin
      dma_request <= 1'b1;
      @(posedge clk);
      dma_request <= 1'b0;
      do @(posedge clk); while (block_end !== 1'b1);
      `CK("src_block", 24'h00_0042, src);
      rd("enable_kept", REG_CTRL, ctl, 32'h0080_0000);
      `CK("idle_wait", 1'b0, xfer_req);
      wr(REG_SRC, 32'h0000_0040);
    end
    wr(REG_CTRL, 32'h0000_0000);
    $display("keep enable test finished");
  endtask : keep_enable

  task automatic bad_addr();
    logic [31:0] d;
    logic [1:0]  r;
    rd("count_reset", REG_COUNT, 32'h0000_0000, ALL_M);
    axr(8'h1c, d, r);
    `CK("rresp_unmapped", RESP_SLVERR, r);
    `CK("rdata_unmapped", 32'h0000_0000, d);
    axw(8'h20, 32'hffff_ffff, r);
    `CK("bresp_unmapped", RESP_SLVERR, r);
    $display("unmapped test finished");
  endtask : bad_addr

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bad_addr();
    run_blk(CM_A, 24'h00_0005, 24'h00_0000, 24'h00_0000, 24, 0, 6, 4'h0);
    run_blk(CM_B, 24'h00_1002, 24'h00_0010, 24'h00_0000, 12, 0, 6, 4'h2);
    // three-word ring: offset of minus two wraps the pointer
    run_blk(CM_B, 24'h00_1002, 24'hff_fffe, 24'h00_0000, 12, 0, 6, 4'h0);
    run_blk(CM_C, 24'h01_0102, 24'h00_0020, 24'h00_0300, 8, 8, 12, 4'h1);
    run_blk(CM_D, 24'h00_1041, 24'h00_0020, 24'h00_0300, 6, 6, 8, 4'h3);
    run_blk(CM_E, 24'h04_1001, 24'h00_0020, 24'h00_0300, 12, 6, 8, 4'h1);
    // joined low and middle, primary offset zero
    run_blk(CM_E, 24'h00_0004, 24'h00_0000, 24'hff_fffc, 12, 6, 5, 4'h0);
    keep_enable();
    complete_run();
  end
endmodule : tb
